// ==== dv/adc_serial_readout_bench.sv ====
// Bench joining both link ends: reads in both frame modes, refusal and abort.
`default_nettype none

module adc_serial_readout_bench
    import asr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk = 1'b0;      // System clock
    logic        rst = 1'b1;       // Reset, active high
    logic        start = 1'b0;     // Host start request
    logic        two_byte = 1'b0;  // Frame mode
    logic        abort = 1'b0;     // Host abort request
    logic        busy;             // Host sequence running
    logic        done;             // Host result pulse
    logic [11:0] result;           // Host result
    logic        frame_ok;         // Leading bit seen
    logic [11:0] sample_in = '0;   // Value to convert
    logic        conv_busy;        // Device converting
    logic        sample_taken;     // Device start pulse
    logic [15:0] cap;              // Bits taken off the wire at rising edges
    int          nrise;            // Rising serial edges in frame
    int          ndone = 0;        // Done pulses seen
    int          ntaken = 0;       // Conversion starts seen
    int          mismatches = 0;
    int          num_checks = 0;
    int          cycles = 0;

    asr_link_if link();
    asr_host i_asr_host (.mclk(mclk), .rst(rst), .start(start), .two_byte(two_byte), .abort(abort),
        .busy(busy), .done(done), .result(result), .frame_ok(frame_ok), .link(link));
    asr_device i_asr_device (.mclk(mclk), .rst(rst), .sample_in(sample_in), .conv_busy(conv_busy),
        .sample_taken(sample_taken), .link(link));
    asr_link_monitor i_asr_link_monitor (.mclk(mclk), .rst(rst), .cs_n(link.cs_n), .sclk(link.sclk),
        .dout(link.dout), .dout_oe(link.dout_oe), .dout_line(link.dout_line));

    // Clock at 200 MHz
    always #2.5 mclk = ~mclk;

    // Wire capture like a master sampling on rising edges; a select fall restarts it
    always @(posedge link.sclk or negedge link.cs_n) begin
        if (link.sclk) begin
            cap <= {cap[14:0], link.dout_line};
            nrise <= nrise + 1;
        end else begin
            nrise <= 0;
        end
    end

    // Pulse counters and hang guard
    always @(posedge mclk) begin
        ndone <= ndone + int'(done === 1'b1);
        ntaken <= ntaken + int'(sample_taken === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    // Bounded wait on a level at falling edges
    task automatic wait_for(ref logic sig, input logic lvl, input int lim);
        for (int n = 0; n < lim && sig !== lvl; n++) begin
            @(negedge mclk);
        end
    endtask : wait_for

    // One start, optionally a second start while busy that must be ignored
    task automatic convert(input logic tb, input logic [11:0] v, input logic refuse);
        int d0;
        int t0;
        d0 = ndone;
        t0 = ntaken;
        sample_in = v;
        two_byte = tb;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        if (refuse) begin
            repeat (100) @(negedge mclk);
            start = 1'b1;
            @(negedge mclk);
            start = 1'b0;
        end
        wait_for(done, 1'b1, 4000);
        check("conv_busy", 16'h0000, {15'h0000, conv_busy});
        check("result", {4'h0, v}, {4'h0, result});
        check("frame_ok", 16'h0001, {15'h0000, frame_ok});
        check("rises", tb ? 16'h0010 : 16'h000d, nrise[15:0]);
        check("wire", tb ? {1'b1, v, 3'h0} : {3'h0, 1'b1, v}, tb ? cap : {3'h0, cap[12:0]});
        wait_for(busy, 1'b0, 400);
        @(negedge mclk);
        check("done_count", 16'(d0 + 1), 16'(ndone));
        check("start_count", 16'(t0 + 1), 16'(ntaken));
    endtask : convert

    // Abort during the conversion wait: no clocks, no result
    task automatic abort_run();
        int d0;
        d0 = ndone;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        repeat (200) @(negedge mclk);
        check("abort_conv_busy", 16'h0001, {15'h0000, conv_busy});
        abort = 1'b1;
        @(negedge mclk);
        abort = 1'b0;
        wait_for(busy, 1'b0, 1000);
        check("abort_done", 16'(d0), 16'(ndone));
        check("abort_rises", 16'h0000, nrise[15:0]);
    endtask : abort_run

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence: boundary codes in both frame modes, back to back
    initial begin
        static logic [11:0] vals [6] = '{12'h000, 12'hfff, 12'ha5a, 12'h801, 12'h5a5, 12'h7fe};
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            convert(i[0], vals[i], i == 2);
        end
        abort_run();
        convert(1'b1, 12'h3c3, 1'b0);
        tally_and_finish();
    end
endmodule : adc_serial_readout_bench

`default_nettype wire

// ==== dv/asr_link_monitor.sv ====
// Checker on the three-wire link between the serial master and the converter.
`default_nettype none

module asr_link_monitor
    import asr_pkg::*;
(
    input  wire logic mclk,      // System clock
    input  wire logic rst,       // Asynchronous reset, active high
    input  wire logic cs_n,      // Select, active low
    input  wire logic sclk,      // Serial clock
    input  wire logic dout,      // Device data value
    input  wire logic dout_oe,   // Device drive enable
    input  wire logic dout_line  // Resolved data wire
);
    logic       eoc_seen;   // End of conversion seen in this frame
    logic       aborted;    // Last frame closed before end of conversion
    logic [4:0] falls;      // Falling serial edges in this frame
    logic [9:0] high_cnt;   // Cycles select stood high, saturating

    // Frame bookkeeping; high_cnt starts full so a start right after reset is legal
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            eoc_seen <= 1'b0;
            aborted  <= 1'b0;
            falls    <= '0;
            high_cnt <= '1;
        end else begin
            eoc_seen <= !cs_n && (eoc_seen || $rose(dout_line));
            falls    <= cs_n ? 5'h00 : falls + 5'($fell(sclk));
            high_cnt <= !cs_n ? 10'h000 : ((high_cnt == '1) ? high_cnt : high_cnt + 10'h001);
            if ($rose(cs_n)) begin
                aborted <= !eoc_seen;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Three sync and flop stages lag behind select, hence five cycles
    hiz_idle_a: assert property (cs_n [*5] |-> !dout_oe)
        else $error("data driven while select high");
    start_drive_a: assert property ($fell(cs_n) |-> ##[1:5] (dout_oe && !dout && !dout_line))
        else $error("data not driven low after select fall");
    sclk_idle_a: assert property (cs_n |-> !sclk)
        else $error("serial clock high outside frame");
    no_clock_conv_a: assert property ($rose(sclk) |-> eoc_seen)
        else $error("serial clock during conversion");
    lead_one_a: assert property ($rose(sclk) && falls == 5'h00 |-> dout_line)
        else $error("leading bit not one");
    trail_zero_a: assert property ($rose(sclk) && falls >= 5'h0d |-> !dout_line)
        else $error("trailing bit not zero");
    edge_only_a: assert property (!cs_n && eoc_seen && $changed(dout_line) |-> $fell(sclk))
        else $error("data changed off a falling edge");
    frame_len_a: assert property ($rose(cs_n) |->
        falls == 5'h00 || falls == 5'h0d || falls == 5'h10)
        else $error("select released at a wrong edge count");
    recovery_a: assert property ($fell(cs_n) |->
        int'(high_cnt) >= (aborted ? ACQ_CYC : SEL_HIGH_REC_CYC))
        else $error("select high time too short");

    // Main scenarios
    cover property ($rose(cs_n) && falls == 5'h0d);
    cover property ($rose(cs_n) && falls == 5'h10);
    cover property ($rose(cs_n) && !eoc_seen);
    cover property ($fell(cs_n) && aborted);
endmodule : asr_link_monitor

`default_nettype wire

// ==== rtl/asr_device.sv ====
// Converter end: conversion timing on mclk, result shifter on the serial clock.
`default_nettype none

module asr_device
    import asr_pkg::*;
(
    input  wire logic               mclk,          // Internal conversion clock
    input  wire logic               rst,           // Asynchronous reset, active high
    input  wire logic [RES_W-1:0]   sample_in,     // Value to be converted
    output logic                    conv_busy,     // Conversion in progress
    output logic                    sample_taken,  // One-cycle pulse at conversion start
    asr_link_if.device              link           // Link side
);

    // Conversion domain
    logic                    cs_s1;      // Select synchroniser, first stage
    logic                    cs_s2;      // Select synchroniser, second stage
    logic                    cs_q;       // Delayed copy for edge detection
    logic [CNT_W-1:0]        ctmr;       // Conversion timer
    logic                    eoc;        // Result ready, drives data before shifting
    logic                    oe;         // Output enable flop
    logic [RES_W-1:0]        held;       // Result, stable from end of conversion

    // Serial clock domain
    logic                    started;    // First falling edge seen this frame
    logic [RES_W-1:0]        shreg;      // Remaining result bits
    logic                    sbit;       // Bit on the data line while shifting

    wire sel_fall = cs_q && !cs_s2;      // Select went low
    wire conv_fin = conv_busy && (ctmr == '0);

    // Before the first falling edge the line shows conversion status
    assign link.dout    = started ? sbit : eoc;
    assign link.dout_oe = oe;

    // Two flops before select reaches the conversion logic; the shifter resets on the raw pin
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_q  <= 1'b1;
        end else begin
            cs_s1 <= link.cs_n;
            cs_s2 <= cs_s1;
            cs_q  <= cs_s2;
        end
    end

    // Conversion timing, independent of the serial clock
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctmr         <= '0;
            eoc          <= 1'b0;
            oe           <= 1'b0;
            held         <= '0;
            conv_busy    <= 1'b0;
            sample_taken <= 1'b0;
        end else begin
            oe           <= !cs_s2;
            sample_taken <= sel_fall;
            if (cs_s2) begin
                // Select high ends or aborts the conversion
                conv_busy <= 1'b0;
                eoc       <= 1'b0;
            end else if (sel_fall) begin
                held      <= sample_in;
                ctmr      <= CNT_W'(DEV_CONV_CYC - 1);
                conv_busy <= 1'b1;
                eoc       <= 1'b0;
            end else if (conv_fin) begin
                conv_busy <= 1'b0;
                eoc       <= 1'b1;
            end else if (conv_busy) begin
                ctmr <= ctmr - CNT_W'(1);
            end
        end
    end

    // Shifter on falling serial clock; select high holds it in frame start.
    // The held word is read only after end of conversion, when the host
    // may clock, so it is stable by then without a synchroniser.
    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            started <= 1'b0;
            shreg   <= '0;
            sbit    <= 1'b0;
        end else if (!started) begin
            started <= 1'b1;
            sbit    <= held[RES_W-1];
            shreg   <= {held[RES_W-2:0], 1'b0};
        end else begin
            sbit    <= shreg[RES_W-1];
            shreg   <= {shreg[RES_W-2:0], 1'b0};
        end
    end

endmodule : asr_device

`default_nettype wire

// ==== rtl/asr_host.sv ====
// Serial master end: select sequencing, clock divider and result capture.
// Overview of operation
// - Host generates serial clock, at most 2.1MHz
// - Select low with serial clock held low
// - Wait data rise or 7.5us timeout
// - Device drives data low during conversion
// - Host supplies at least 13 clocks
// - MSB after first falling edge, descending
// - Device changes on fall, host samples rise
// - Release select at/after 13th falling edge
// - Extra falling edges shift out zeros
// - Keep select high minimum recovery time
// - After abort wait acquisition time
// - Select held low until all bits out
// - Frame: leading one, twelve bits, zeros
// - Clock polarity zero, phase zero
// - Byte master does two 8-bit transfers
// - Bytes: one plus seven, five plus zeros
// - Thirteen-clock read has no trailing zeros
// - Queued master clock at most 2.097MHz
// - No serial clock during conversion
// - Data high impedance while select high
`default_nettype none

module asr_host
    import asr_pkg::*;
(
    input  wire logic               mclk,      // System clock
    input  wire logic               rst,       // Asynchronous reset, active high
    input  wire logic               start,     // Begin a conversion when idle
    input  wire logic               two_byte,  // 1: two 8-bit transfers, 0: thirteen clocks
    input  wire logic               abort,     // Abort a conversion in progress
    output logic                    busy,      // Sequence in progress
    output logic                    done,      // One-cycle pulse, result valid
    output logic [RES_W-1:0]        result,    // Last result
    output logic                    frame_ok,  // Leading bit of last frame was one
    asr_link_if.host                link       // Link side
);

    // Sequence of one read, in mclk cycles:
    //   idle      select high, clock low, waiting for start
    //   conv      select low; ends on synced data high or on the timeout
    //   shift     13 or 16 clock periods of two half periods each
    //   tail      one more half period with select low after the last fall
    //   recov     select high for the recovery or acquisition time
    // The data pin is sampled only through two flops, so the end of
    // conversion is seen two cycles late; the timeout covers a device
    // that never raises its data line.
    // Capture happens on the cycle the clock flop goes high, using the
    // synced copy of a bit that changed a whole half period earlier.
    // Limitation: the half period must stay well above the sync delay,
    // or the captured bit would be the one before.
    // two_byte is taken with start and held in the clock count.
    // Trade-off: a mode change while busy waits for the next start.

    asr_state_e              state;       // Sequencer state
    logic [CNT_W-1:0]        tmr;         // Wait timer
    logic [CNT_W-1:0]        ph;          // Half-period divider
    logic [CLKCNT_W-1:0]     nrise;       // Rising edges issued this frame
    logic [CLKCNT_W-1:0]     nclk;        // Clocks wanted this frame
    logic [FRAME_BYTE_CLK-1:0] shin;      // Captured serial bits
    logic                    dout_s1;     // Data synchroniser, first stage
    logic                    dout_s2;     // Data synchroniser, second stage
    logic                    cs_n_q;      // Select pin flop
    logic                    sclk_q;      // Serial clock pin flop

    // Split a captured frame into leading bit and result.
    // Byte mode: the frame fills all sixteen bits and the three
    // trailing zeros sit at the bottom; thirteen-clock mode uses
    // the low thirteen bits only.
    function automatic logic [RES_W:0] take_frame(input logic [FRAME_BYTE_CLK-1:0] f,
                                                  input logic bytes);
        take_frame = bytes ? f[FRAME_BYTE_CLK-1:FRAME_BYTE_CLK-RES_W-1] : f[RES_W:0];
    endfunction : take_frame

    // Decoded conditions used by the sequencer
    wire             ph_end      = (ph == '0);                          // Half period elapsed
    wire             rise_now    = ph_end && !sclk_q;                   // Next toggle is rising
    wire             last_fall   = ph_end && sclk_q && (nrise == nclk); // Final falling edge
    wire             conv_end    = dout_s2 || (tmr == '0);
    // Mode from the latched clock count, not the live input
    wire             bytes_mode  = (nclk == CLKCNT_W'(FRAME_BYTE_CLK)); // Frame mode taken at start
    wire [RES_W:0]   frame_bits  = take_frame(shin, bytes_mode);        // Leading bit and result
    wire [CLKCNT_W-1:0] want_clk = two_byte ? CLKCNT_W'(FRAME_BYTE_CLK)
                                            : CLKCNT_W'(FRAME_MIN_CLK);

    // Pins come straight from flops
    assign link.cs_n = cs_n_q;
    assign link.sclk = sclk_q;

    // Two flops before the data pin reaches any logic
    // The first stage may go metastable; only the second stage reads it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dout_s1 <= 1'b0;
            dout_s2 <= 1'b0;
        end else begin
            dout_s1 <= link.dout_line;
            dout_s2 <= dout_s1;
        end
    end

    // Sequencer: select, divider, capture
    // One process keeps divider and capture in step with the state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            // Idle pins: select high, clock low
            state    <= ST_IDLE;
            cs_n_q   <= 1'b1;
            sclk_q   <= 1'b0;
            tmr      <= '0;
            ph       <= '0;
            nrise    <= '0;
            nclk     <= '0;
            shin     <= '0;
            busy     <= 1'b0;
            done     <= 1'b0;
            result   <= '0;
            frame_ok <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                // Waiting for a start request
                ST_IDLE: begin
                    sclk_q <= 1'b0;
                    if (start) begin
                        // Select falls with clock low; sample is held from here
                        cs_n_q <= 1'b0;
                        busy   <= 1'b1;
                        nclk   <= want_clk;
                        tmr    <= CNT_W'(CONV_MAX_CYC - 1);
                        state  <= ST_CONV;
                    end
                end

                // Waiting for end of conversion or the timeout
                ST_CONV: begin
                    // Clock stays low the whole conversion
                    sclk_q <= 1'b0;
                    tmr    <= tmr - CNT_W'(1);
                    if (abort) begin
                        // Aborted sample needs a full acquisition before the next
                        cs_n_q <= 1'b1;
                        tmr    <= CNT_W'(ACQ_CYC - 1);
                        state  <= ST_RECOV;
                    end else if (conv_end) begin
                        nrise <= '0;
                        ph    <= CNT_W'(SCLK_HALF_CYC - 1);
                        state <= ST_SHIFT;
                    end
                end

                // Serial clock running, bits taken on rising edges
                ST_SHIFT: begin
                    // Divider keeps each phase at least a half period
                    ph <= ph_end ? CNT_W'(SCLK_HALF_CYC - 1) : ph - CNT_W'(1);
                    if (ph_end) begin
                        sclk_q <= !sclk_q;
                    end
                    if (rise_now) begin
                        // Data changed a half period ago; the synced copy has settled
                        shin  <= {shin[FRAME_BYTE_CLK-2:0], dout_s2};
                        nrise <= nrise + CLKCNT_W'(1);
                    end
                    if (last_fall) begin
                        state <= ST_TAIL;
                    end
                end

                // Last fall done, select still low
                ST_TAIL: begin
                    // Hold select low one more half period after the last fall
                    ph <= ph - CNT_W'(1);
                    if (ph_end) begin
                        cs_n_q   <= 1'b1;
                        result   <= frame_bits[RES_W-1:0];
                        frame_ok <= frame_bits[RES_W];
                        done     <= 1'b1;
                        tmr      <= CNT_W'(SEL_HIGH_REC_CYC - 1);
                        state    <= ST_RECOV;
                    end
                end

                // Select high for the minimum time
                ST_RECOV: begin
                    // Select stays high until the recovery time is over
                    tmr <= tmr - CNT_W'(1);
                    if (tmr == '0) begin
                        busy  <= 1'b0;
                        state <= ST_IDLE;
                    end
                end

                // Unused codes return to a safe idle
                default: begin
                    cs_n_q <= 1'b1;
                    sclk_q <= 1'b0;
                    busy   <= 1'b0;
                    state  <= ST_IDLE;
                end
            endcase
        end
    end

endmodule : asr_host

`default_nettype wire

// ==== rtl/asr_link_if.sv ====
// Three-wire link between the serial master and the converter.
`default_nettype none

interface asr_link_if;
    logic cs_n;      // Active-low select, driven by host
    logic sclk;      // Serial clock, driven by host
    logic dout;      // Data value driven by the device
    logic dout_oe;   // Device drives data while high
    wire  dout_line; // Resolved data wire, pulled low when undriven

    // Weak pull-down keeps an undriven line from reading as end of conversion
    assign dout_line = dout_oe ? dout : 1'b0;

    modport device (input cs_n, input sclk, output dout, output dout_oe);
    modport host   (output cs_n, output sclk, input dout_line);
endinterface : asr_link_if

`default_nettype wire

// ==== rtl/asr_pkg.sv ====
// Shared constants for the serial converter readout link, both ends.
`default_nettype none

package asr_pkg;

    // Clock of both user sides
    localparam int CLK_HZ            = 200_000_000;  // mclk rate
    localparam int CLK_NS            = 5;            // mclk period in ns

    // Result and frame shape
    localparam int RES_W             = 12;           // Result bits per conversion
    localparam int FRAME_MIN_CLK     = 13;           // Leading one plus twelve bits
    localparam int FRAME_BYTE_CLK    = 16;           // Two whole bytes
    localparam int CLKCNT_W          = 5;            // Width of serial clock counters
    localparam int CNT_W             = 11;           // Width of timing counters

    // Conversion timing
    localparam int CONV_MAX_NS       = 7500;         // Worst-case conversion time
    localparam int CONV_MAX_CYC      = (CONV_MAX_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEV_CONV_NS       = 7000;         // Conversion time the device model takes
    localparam int DEV_CONV_CYC      = (DEV_CONV_NS + CLK_NS - 1) / CLK_NS;

    // Recovery times after select rises
    localparam int ACQ_NS            = 1500;         // Acquisition time after an abort
    localparam int ACQ_CYC           = (ACQ_NS + CLK_NS - 1) / CLK_NS;
    localparam int SEL_HIGH_REC_NS   = 100;          // select_high_recovery_time
    localparam int SEL_HIGH_REC_CYC  = (SEL_HIGH_REC_NS + CLK_NS - 1) / CLK_NS;

    // Serial clock limits; the stricter one sets the divider
    localparam int SCLK_MAX_HZ       = 2_100_000;    // General serial clock limit
    localparam int QSCLK_MAX_HZ      = 2_097_000;    // Queued-master serial clock limit
    localparam int SCLK_HALF_CYC     = (CLK_HZ + 2 * QSCLK_MAX_HZ - 1) / (2 * QSCLK_MAX_HZ);

    // Host sequencer states, Gray from idle through to recovery
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,   // Select high, waiting for a start
        ST_CONV  = 3'h1,   // Select low, waiting for end of conversion
        ST_SHIFT = 3'h3,   // Serial clock running
        ST_TAIL  = 3'h2,   // Last falling edge done, hold before release
        ST_RECOV = 3'h6    // Select high, minimum high time
    } asr_state_e;

endpackage : asr_pkg

`default_nettype wire
